// >>> logic/async_rx_clock_data_recovery.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Sample at 16x baud in normal mode, 8x in double speed.
// - Double speed select one picks 8x sampling, zero picks 16x.
// - Start search begins on idle-high to low; first low is sample one.
// - Start qualified by samples 8,9,10 normal, or 4,5,6 double speed.
// - Two or more high qualifying samples reject start as noise.
// - Sample phase resynchronises on every accepted start bit.
// - Sixteen states per bit normal, eight in double speed.
// - Bit value is majority of three centre samples.
// - Recover data and parity up to first stop bit; later stops ignored.
// - Stop bit resolved by majority; zero sets framing error flag.
// - Normal mode accepts next falling edge right after last stop vote.
// - Framing error flag is zero when the stop bit resolved as one.
module async_rx_clock_data_recovery
    import rx_recovery_pkg::*;
(
    input  wire logic                  clk_sys,
    input  wire logic                  reset_n,
    input  wire logic                  clkEnable,
    input  wire logic                  sampleTick,
    input  wire logic                  double_speed_select,
    input  wire logic [3:0]            frameBits,
    input  wire logic                  serialIn,
    output logic [DATA_WIDTH-1:0]      rxBits,
    output logic                       framing_error_flag,
    output logic                       frameValid,
    output logic                       rxBusy
);
    typedef struct packed {
        rx_state_e              state;
        logic [3:0]             sample;
        logic [3:0]             bitCount;
        logic [3:0]             bitsTotal;
        logic                   fast;
        logic [2:0]             votes;
        logic                   lastLine;
        logic [DATA_WIDTH-1:0]  shift;
        logic [DATA_WIDTH-1:0]  bitsOut;
        logic                   frameErr;
        logic                   valid;
        logic                   busy;
    } rx_s;

    rx_s rxQ;
    rx_s rxD;
    logic lineLevel;
    logic bitValue;
    logic       bitEnd;
    logic       lineVote;
    logic [3:0] curSample;

    rx_pin_sync pinSync (
        .clk_sys   (clk_sys),
        .reset_n   (reset_n),
        .clkEnable (clkEnable),
        .pinIn     (serialIn),
        .pinLevel  (lineLevel)
    );

    function automatic logic majority(input logic [2:0] v);
        return (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
    endfunction : majority

    function automatic logic [3:0] lastSample(input logic fast);
        return fast ? LAST_DOUBLE : LAST_NORMAL;
    endfunction : lastSample

    function automatic logic [3:0] voteFirst(input logic fast);
        return fast ? VOTE_DOUBLE : VOTE_NORMAL;
    endfunction : voteFirst

    function automatic logic inVote(input logic [3:0] s, input logic fast);
        logic [3:0] first;
        first = voteFirst(fast);
        return s >= first && s <= first + 4'h2;
    endfunction : inVote

    function automatic logic voteDone(input logic [3:0] s, input logic fast);
        logic [3:0] first;
        first = voteFirst(fast);
        return s == first + 4'h2;
    endfunction : voteDone

    // Normal mode decides the stop at its last vote and re-arms there;
    // double speed waits out the bit, trading a later start for a
    // simpler count
    function automatic logic stopReady(input logic [3:0] s,
                                       input logic       last,
                                       input logic       fast);
        logic ready;
        ready = fast ? last : voteDone(s, fast);
        return ready;
    endfunction : stopReady

    // Out-of-range sizes are clamped rather than refused, so a bad
    // setting still yields frames of a defined length
    function automatic logic [3:0] clampBits(input logic [3:0] n);
        logic [3:0] r;
        r = n;
        if (n < MIN_BITS) begin
            r = MIN_BITS;
        end else if (n > MAX_BITS) begin
            r = MAX_BITS;
        end
        return r;
    endfunction : clampBits

    // The stored count is the number of the sample last taken, so the
    // sample taken at this tick is one more; sixteen wraps to zero
    assign curSample = rxQ.sample + 4'h1;
    assign bitEnd    = rxQ.sample == lastSample(rxQ.fast);
    assign bitValue  = majority(rxQ.votes);
    assign lineVote  = majority({rxQ.votes[1:0], lineLevel});

    always_comb begin
        rxD = rxQ;
        rxD.valid = 1'b0;
        if (sampleTick) begin
            // Edge memory only moves on ticks, so a glitch that falls
            // between two ticks is never seen as a start
            rxD.lastLine = lineLevel;
            if (rxQ.state != ST_IDLE) begin
                rxD.sample = curSample;
                if (bitEnd) begin
                    rxD.sample = COUNT_ZERO;
                end
                // Each bit refills all three votes before they are used
                if (inVote(curSample, rxQ.fast)) begin
                    rxD.votes = {rxQ.votes[1:0], lineLevel};
                end
            end
            case (rxQ.state)
                ST_IDLE: begin
                    // Mode and size latched per frame so a mid-frame change
                    // cannot tear the sample sequence
                    if (rxQ.lastLine && !lineLevel) begin
                        rxD.state = ST_START;
                        rxD.sample = FIRST_SAMPLE;
                        rxD.fast = double_speed_select;
                        rxD.bitsTotal = clampBits(frameBits);
                        rxD.bitCount = COUNT_ZERO;
                        rxD.shift = DATA_ZERO;
                        rxD.busy = 1'b1;
                    end
                end

                ST_START: begin
                    // Noise goes back to the hunt without a frame
                    if (voteDone(curSample, rxQ.fast) && lineVote) begin
                        rxD.state = ST_IDLE;
                        rxD.busy = 1'b0;
                    end else if (bitEnd) begin
                        rxD.state = ST_BITS;
                    end
                end

                ST_BITS: begin
                    if (bitEnd) begin
                        // Bits land LSB first, at bit index bitCount
                        rxD.shift[rxQ.bitCount] = bitValue;
                        rxD.bitCount = rxQ.bitCount + 4'h1;
                        if (rxQ.bitCount + 4'h1 == rxQ.bitsTotal) begin
                            rxD.state = ST_STOP;
                        end
                    end
                end

                ST_STOP: begin
                    if (stopReady(curSample, bitEnd, rxQ.fast)) begin
                        if (rxQ.fast) begin
                            rxD.frameErr = !bitValue;
                        end else begin
                            rxD.frameErr = !lineVote;
                        end
                        rxD.bitsOut = rxQ.shift;
                        rxD.valid = 1'b1;
                        rxD.state = ST_IDLE;
                        rxD.busy = 1'b0;
                        // Line counted high, so a low at the next tick
                        // already opens a new start
                        rxD.lastLine = 1'b1;
                    end
                end

                default: begin
                    // Unreachable codes fall back to the hunt
                    rxD.state = ST_IDLE;
                    rxD.busy = 1'b0;
                end
            endcase
        end
    end

    // Line taken as idle high in reset, so release brings no false start
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rxQ <= '{state:     ST_IDLE,
                     sample:    COUNT_ZERO,
                     bitCount:  COUNT_ZERO,
                     bitsTotal: MAX_BITS,
                     fast:      1'b0,
                     votes:     3'h0,
                     lastLine:  1'b1,
                     shift:     DATA_ZERO,
                     bitsOut:   DATA_ZERO,
                     frameErr:  1'b0,
                     valid:     1'b0,
                     busy:      1'b0};
        end else if (clkEnable) begin
            rxQ <= rxD;
        end
    end

    // Every output is a field of the state register

    assign rxBits = rxQ.bitsOut;
    assign framing_error_flag = rxQ.frameErr;
    assign frameValid = rxQ.valid;
    assign rxBusy = rxQ.busy;
endmodule : async_rx_clock_data_recovery

// >>> inc/rx_recovery_pkg.sv
package rx_recovery_pkg;
    localparam int          SAMPLES_NORMAL  = 16;
    localparam int          SAMPLES_DOUBLE  = 8;
    localparam logic [3:0]  LAST_NORMAL     = 4'hf;
    localparam logic [3:0]  LAST_DOUBLE     = 4'h7;
    localparam logic [3:0]  VOTE_NORMAL     = 4'h8;
    localparam logic [3:0]  VOTE_DOUBLE     = 4'h4;
    localparam logic [3:0]  FIRST_SAMPLE    = 4'h1;
    localparam logic [3:0]  MIN_BITS        = 4'h5;
    localparam logic [3:0]  MAX_BITS        = 4'ha;
    localparam logic [3:0]  COUNT_ZERO      = 4'h0;
    localparam logic [9:0]  DATA_ZERO       = 10'h000;
    localparam int          DATA_WIDTH      = 10;
    localparam logic [2:0]  SYNC_IDLE       = 3'h7;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_START,
        ST_BITS,
        ST_STOP
    } rx_state_e;
endpackage : rx_recovery_pkg

// >>> logic/rx_pin_sync.sv
`timescale 1ns/1ps
// Three-stage pin synchroniser; a change counts once stages two and three agree
module rx_pin_sync
    import rx_recovery_pkg::*;
(
    input  wire logic clk_sys,
    input  wire logic reset_n,
    input  wire logic clkEnable,
    input  wire logic pinIn,
    output logic      pinLevel
);
    typedef struct packed {
        logic [2:0] stages;
        logic       level;
    } sync_s;

    sync_s syncQ;
    sync_s syncD;

    always_comb begin
        syncD = syncQ;
        syncD.stages = {syncQ.stages[1:0], pinIn};
        // Only stages two and three are compared; stage one is metastable
        if (syncQ.stages[2] == syncQ.stages[1]) begin
            syncD.level = syncQ.stages[2];
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            syncQ <= '{stages: SYNC_IDLE, level: 1'b1};
        end else if (clkEnable) begin
            syncQ <= syncD;
        end
    end

    assign pinLevel = syncQ.level;
endmodule : rx_pin_sync

// >>> testbench/rx_recovery_chk.sv
`timescale 1ns/1ps
module rx_recovery_chk
    import rx_recovery_pkg::*;
(
    input wire logic                  clk_sys,
    input wire logic                  reset_n,
    input wire logic                  clkEnable,
    input wire logic                  sampleTick,
    input wire logic [3:0]            frameBits,
    input wire logic [DATA_WIDTH-1:0] rxBits,
    input wire logic                  framing_error_flag,
    input wire logic                  frameValid,
    input wire logic                  rxBusy
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    valid_pulse_a: assert property (frameValid |=> !frameValid)
        else $error("frame valid held too long");
    valid_ends_a: assert property (frameValid |-> $fell(rxBusy))
        else $error("busy not dropped at frame end");
    bits_hold_a: assert property (!frameValid |-> $stable(rxBits))
        else $error("bits changed between frames");
    flag_hold_a: assert property (
        !frameValid |-> $stable(framing_error_flag))
        else $error("flag changed between frames");
    busy_tick_a: assert property (
        $changed(rxBusy) |-> $past(sampleTick && clkEnable))
        else $error("busy moved off a tick");
    valid_tick_a: assert property (
        frameValid |-> $past(sampleTick && clkEnable))
        else $error("frame ended off a tick");
    start_window_a: assert property ($rose(rxBusy) |=> rxBusy [*4])
        else $error("start dropped before its vote");
    high_zero_a: assert property (
        frameValid |-> (rxBits >> frameBits) == DATA_ZERO)
        else $error("unused bits not zero");
endmodule : rx_recovery_chk
bind async_rx_clock_data_recovery rx_recovery_chk chk (
    .clk_sys(clk_sys), .reset_n(reset_n), .clkEnable(clkEnable),
    .sampleTick(sampleTick), .frameBits(frameBits), .rxBits(rxBits),
    .framing_error_flag(framing_error_flag), .frameValid(frameValid),
    .rxBusy(rxBusy));

// >>> testbench/remote_tx.sv
`timescale 1ns/1ps
// Bits last a whole number of ticks, so the rate error is zero
module remote_tx (
    input  wire logic clk_sys,
    input  wire logic sampleTick,
    output logic      txLine
);
    initial txLine = 1'b1;
    task automatic put(input logic v, input int n);
        @(negedge clk_sys);
        txLine = v;
        repeat (n) @(posedge clk_sys iff sampleTick);
    endtask : put
    // Ends without idling, so a start may follow at once
    task automatic send(input logic [9:0] d, input int nb, input int spb,
                        input logic stopLvl, input int stopTicks);
        put(1'b0, spb);
        for (int i = 0; i < nb; i++) put(d[i], spb);
        put(stopLvl, stopTicks);
    endtask : send
endmodule : remote_tx

// >>> testbench/testbench.sv
`timescale 1ns/1ps
module testbench
    import rx_recovery_pkg::*;
;
    logic                  clk_sys = 1'b0;
    logic                  reset_n = 1'b0;
    logic                  sampleTick = 1'b0;
    logic                  clkEnable = 1'b1;
    logic                  double_speed_select = 1'b0;
    logic [3:0]            frameBits = 4'h8;
    logic                  serialIn;
    logic [DATA_WIDTH-1:0] rxBits;
    logic                  flag, frameValid, rxBusy;
    logic [10:0]           got[$];
    int                    bad_count = 0, comparisons = 0, cycles = 0;
    async_rx_clock_data_recovery uut (
        .clk_sys(clk_sys), .reset_n(reset_n), .clkEnable(clkEnable),
        .sampleTick(sampleTick), .double_speed_select(double_speed_select),
        .frameBits(frameBits), .serialIn(serialIn), .rxBits(rxBits),
        .framing_error_flag(flag), .frameValid(frameValid), .rxBusy(rxBusy));
    remote_tx tx (.clk_sys(clk_sys), .sampleTick(sampleTick),
                  .txLine(serialIn));
    always #5 clk_sys = ~clk_sys;
    always @(negedge clk_sys) sampleTick <= (cycles % 4 == 3);
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (frameValid === 1'b1) got.push_back({flag, rxBits});
        if (cycles == 20000) begin
            bad_count++;
            complete_run();
        end
    end
    task automatic complete_run();
        $display("mismatches %0d comparisons %0d", bad_count, comparisons);
        if (bad_count == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : complete_run
    task automatic check(input logic [10:0] g, input logic [10:0] e);
        comparisons++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value at %0t got %h expected %h", $time, g, e);
        end
    endtask : check
    task automatic expect_frame(input logic [10:0] e);
        for (int n = 0; n < 200 && got.size() == 0; n++) @(posedge clk_sys);
        check(got.size() != 0 ? got.pop_front() : ~e, e);
    endtask : expect_frame
    task automatic set_mode(input logic dss, input logic [3:0] nb);
        @(negedge clk_sys);
        double_speed_select = dss;
        frameBits = nb;
    endtask : set_mode
    task automatic good_frame();
        tx.send(10'h0a5, 8, 16, 1'b1, 16);
        expect_frame({1'b0, 10'h0a5});
    endtask : good_frame
    task automatic bad_stop();
        set_mode(1'b0, 4'h5);
        tx.send(10'h016, 5, 16, 1'b0, 16);
        tx.put(1'b1, 16);
        expect_frame({1'b1, 10'h016});
    endtask : bad_stop
    task automatic back_to_back();
        set_mode(1'b0, 4'h8);
        tx.send(10'h0c3, 8, 16, 1'b1, 10);
        tx.send(10'h05a, 8, 16, 1'b1, 16);
        expect_frame({1'b0, 10'h0c3});
        expect_frame({1'b0, 10'h05a});
    endtask : back_to_back
    // Low through sample 8 only: two of three votes high
    task automatic noise_reject();
        tx.put(1'b0, 8);
        tx.put(1'b1, 24);
        check({rxBusy, 10'(got.size())}, 11'h000);
    endtask : noise_reject
    // Enable low freezes the synchroniser too, so the frame is never seen
    task automatic frozen_frame();
        set_mode(1'b0, 4'h8);
        @(negedge clk_sys);
        clkEnable = 1'b0;
        tx.send(10'h0f0, 8, 16, 1'b1, 16);
        @(negedge clk_sys);
        clkEnable = 1'b1;
        tx.put(1'b1, 16);
        check({rxBusy, 10'(got.size())}, 11'h000);
    endtask : frozen_frame
    task automatic double_frame();
        set_mode(1'b1, 4'ha);
        tx.send(10'h2c9, 10, 8, 1'b1, 8);
        tx.put(1'b1, 8);
        expect_frame({1'b0, 10'h2c9});
    endtask : double_frame
    initial begin
        repeat (3) @(negedge clk_sys);
        reset_n = 1'b1;
        tx.put(1'b1, 4);
        good_frame();
        bad_stop();
        back_to_back();
        noise_reject();
        frozen_frame();
        double_frame();
        complete_run();
    end
endmodule : testbench
